// ==== fss_state_save.sv ====
// Purpose: save-interface answer and opcode check for fp state save
// Assumes: host reads the save word, then reports the frame stored
// Notes:   frame contents and the restore path live elsewhere
// Notes on behaviour
// - answer not-ready while operation can finish
// - save during save returns illegal word
// - null frame when untouched since reset
// - null implies reset programmer model
// - idle length follows implementation variant
// - idle only when done, no exceptions; code also picks idle with op_running set and op_can_finish clear
// - unimplemented frame only integrated, 48 bytes
// - no unimplemented_type_frame frame with late exceptions
// - busy frame on exception, variant length
// - save leaves visible fp registers alone
// - status register untouched by save
// - accept only listed address modes
// - six format words on save register
// - format word is frame's first word
`timescale 1ns/1ps
module fss_state_save
   import fss_pkg::*;
#(
   parameter logic [1:0] VARIANT = FSS_VAR_INTEG
)(
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic        clk_en,
   input  wire logic [2:0]  cop_id,
   input  wire logic        instr_valid,
   input  wire logic [15:0] instr_word,
   input  wire logic        save_rd,
   input  wire logic        frame_stored,
   input  wire logic        op_running,
   input  wire logic        op_can_finish,
   input  wire logic        fp_activity,
   input  wire logic        restore_null,
   input  wire logic        unimpl_instr,
   input  wire logic        exc_early,
   input  wire logic        exc_late,
   input  wire logic        exc_unsupp,
   input  wire logic        exc_other,
   output logic             save_instr_r,
   output logic             ea_reject_r,
   output logic             save_valid_r,
   output logic [15:0]      save_word_r,
   output logic [7:0]       frame_len_r,
   output logic             model_is_reset_r,
   output logic             saving_r
);

   ////////////////////////////////////////////////////////////////////
   // decode

   function automatic logic ea_allowed(input logic [5:0] ea);
      logic [2:0] m;
      logic [2:0] r;
      m = ea[5:3];
      r = ea[2:0];
      ea_allowed = (m == FSS_EA_IND) || (m == FSS_EA_PREDEC) ||
                   (m == FSS_EA_DISP) || (m == FSS_EA_INDEX) ||
                   ((m == FSS_EA_EXT) &&
                    ((r == FSS_EA_ABS_W) || (r == FSS_EA_ABS_L)));
   endfunction : ea_allowed

   wire logic op_match = instr_valid &&
      (instr_word[FSS_OP_LINE_HI:FSS_OP_LINE_LO] == FSS_OP_LINE) &&
      (instr_word[FSS_OP_ID_HI:FSS_OP_ID_LO] == cop_id) &&
      (instr_word[FSS_OP_TYPE_HI:FSS_OP_TYPE_LO] == FSS_OP_TYPE);
   wire logic ea_ok = ea_allowed(instr_word[FSS_OP_MODE_HI:FSS_OP_REG_LO]);

   ////////////////////////////////////////////////////////////////////
   // frame choice

   fss_state_e state_r;
   fss_state_e state_nxt;
   logic       modified_r;

   wire logic is_integ  = (VARIANT == FSS_VAR_INTEG);
   wire logic len_sel_a = (VARIANT == FSS_VAR_EXT_A);

   wire logic [7:0] idle_len = is_integ ? FSS_LEN_IDLE_INT :
      (len_sel_a ? FSS_LEN_IDLE_A : FSS_LEN_IDLE_B);
   wire logic [7:0] busy_len = is_integ ? FSS_LEN_BUSY_INT :
      (len_sel_a ? FSS_LEN_BUSY_A : FSS_LEN_BUSY_B);

   // late, unsupported or other exceptions force a busy frame once the null and not-ready answers are passed
   wire logic want_busy  = exc_late || exc_unsupp || exc_other;
   wire logic want_utype = is_integ && !want_busy &&
                           (unimpl_instr || exc_early);
   wire logic busy_any   = want_busy || (!is_integ && exc_early);
   wire logic wait_op    = op_running && op_can_finish;

   logic [15:0] fmt_sel;
   logic [7:0]  len_sel;
   logic        start_save;

   always_comb begin
      fmt_sel    = FSS_FMT_NULL;
      len_sel    = FSS_LEN_NULL;
      start_save = 1'b0;
      if (state_r == FSS_ST_SAVING) begin
         fmt_sel = FSS_FMT_ILLEGAL;
      end else if (!modified_r) begin
         start_save = 1'b1;
      end else if (wait_op) begin
         fmt_sel = FSS_FMT_NOT_READY;
      end else if (busy_any) begin
         fmt_sel    = {FSS_VERSION, FSS_FMT_BUSY_LO};
         len_sel    = busy_len;
         start_save = 1'b1;
      end else if (want_utype) begin
         fmt_sel    = {FSS_VERSION, FSS_FMT_UTYPE_LO};
         len_sel    = FSS_LEN_UTYPE;
         start_save = 1'b1;
      end else begin
         fmt_sel    = {FSS_VERSION, FSS_FMT_IDLE_LO};
         len_sel    = idle_len;
         start_save = 1'b1;
      end
   end

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         FSS_ST_READY: begin
            if (save_rd && start_save)
               state_nxt = FSS_ST_SAVING;
         end
         FSS_ST_SAVING: begin
            if (frame_stored)
               state_nxt = FSS_ST_READY;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // registers

   // activity wins over a null restore in the same cycle
   wire logic modified_nxt = fp_activity ? 1'b1 :
                             (restore_null ? 1'b0 : modified_r);

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state_r    <= FSS_ST_READY;
         modified_r <= 1'b0;
      end else if (clk_en) begin
         state_r    <= state_nxt;
         modified_r <= modified_nxt;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         save_valid_r <= 1'b0;
         save_word_r  <= 16'h0000;
         frame_len_r  <= 8'h00;
      end else if (clk_en) begin
         save_valid_r <= save_rd;
         if (save_rd) begin
            save_word_r <= fmt_sel;
            frame_len_r <= len_sel;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         save_instr_r     <= 1'b0;
         ea_reject_r      <= 1'b0;
         model_is_reset_r <= 1'b1;
         saving_r         <= 1'b0;
      end else if (clk_en) begin
         save_instr_r     <= op_match && ea_ok;
         ea_reject_r      <= op_match && !ea_ok;
         model_is_reset_r <= !modified_nxt;
         // saving touches no visible register nor the status word
         saving_r         <= (state_nxt == FSS_ST_SAVING);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks

   sequence s_rd_ready;
      clk_en && save_rd && (state_r == FSS_ST_READY);
   endsequence

   sequence s_answer(logic [15:0] w);
      save_valid_r && (save_word_r == w);
   endsequence

   AST_NOT_READY: assert property (@(posedge sys_clk) disable iff (srst)
      s_rd_ready and (modified_r && op_running && op_can_finish)
      |=> s_answer(FSS_FMT_NOT_READY) ##0 (state_r == FSS_ST_READY))
      else $error("not-ready word missing");

   AST_ILLEGAL: assert property (@(posedge sys_clk) disable iff (srst)
      clk_en && save_rd && (state_r == FSS_ST_SAVING)
      |=> s_answer(FSS_FMT_ILLEGAL))
      else $error("illegal word missing during save");

   AST_NULL: assert property (@(posedge sys_clk) disable iff (srst)
      s_rd_ready and !modified_r
      |=> s_answer(FSS_FMT_NULL) ##0 (frame_len_r == FSS_LEN_NULL))
      else $error("null frame not chosen");

   AST_IDLE: assert property (@(posedge sys_clk) disable iff (srst)
      save_valid_r && (save_word_r[7:0] == FSS_FMT_IDLE_LO) &&
      (save_word_r[15:8] == FSS_VERSION)
      |-> (frame_len_r == idle_len) && !$past(exc_late) &&
          !$past(exc_early) && !$past(exc_other))
      else $error("idle frame with exception pending");

   AST_NO_UTYPE: assert property (@(posedge sys_clk) disable iff (srst)
      save_valid_r && (save_word_r[7:0] == FSS_FMT_UTYPE_LO)
      |-> !$past(exc_late) && !$past(exc_unsupp) && is_integ &&
          (frame_len_r == FSS_LEN_UTYPE))
      else $error("unimplemented-type frame with late exception");

   AST_BUSY: assert property (@(posedge sys_clk) disable iff (srst)
      s_rd_ready and (modified_r && !wait_op && exc_early && exc_late)
      |=> s_answer({FSS_VERSION, FSS_FMT_BUSY_LO}) ##0
          (frame_len_r == busy_len))
      else $error("busy frame not chosen");

   AST_DECODE: assert property (@(posedge sys_clk) disable iff (srst)
      clk_en && instr_valid && (instr_word[15:12] == 4'hf) &&
      (instr_word[11:9] == cop_id) && (instr_word[8:6] == 3'h4) &&
      (instr_word[5:3] == 3'h3)
      |=> ea_reject_r && !save_instr_r)
      else $error("postincrement accepted");

   AST_BACK_READY: assert property (@(posedge sys_clk) disable iff (srst)
      clk_en && (state_r == FSS_ST_SAVING) && frame_stored
      |=> (state_r == FSS_ST_READY) && !saving_r)
      else $error("not idle after save");

endmodule : fss_state_save

// ==== fss_pkg.sv ====
// Purpose: constants for the fp state-save handshake block
// Assumes: 16-bit save interface word, byte-sized frame lengths
// Notes:   version byte and unimplemented-type low byte are neutral values
package fss_pkg;
   // format words returned on the save interface register
   localparam logic [15:0] FSS_FMT_NULL      = 16'h0018;
   localparam logic [15:0] FSS_FMT_NOT_READY = 16'h0118;
   localparam logic [15:0] FSS_FMT_ILLEGAL   = 16'h0218;
   localparam logic [7:0]  FSS_FMT_IDLE_LO   = 8'h18;
   localparam logic [7:0]  FSS_FMT_BUSY_LO   = 8'hb4;
   localparam logic [7:0]  FSS_FMT_UTYPE_LO  = 8'h30;
   // version byte: arbitrary value
   localparam logic [7:0]  FSS_VERSION       = 8'h5a;

   // implementation variants
   localparam logic [1:0]  FSS_VAR_INTEG     = 2'h0;
   localparam logic [1:0]  FSS_VAR_EXT_A     = 2'h1;
   localparam logic [1:0]  FSS_VAR_EXT_B     = 2'h2;

   // frame lengths in bytes
   localparam logic [7:0]  FSS_LEN_NULL      = 8'h04;
   localparam logic [7:0]  FSS_LEN_IDLE_INT  = 8'h04;
   localparam logic [7:0]  FSS_LEN_IDLE_A    = 8'h1c;
   localparam logic [7:0]  FSS_LEN_IDLE_B    = 8'h3c;
   localparam logic [7:0]  FSS_LEN_UTYPE     = 8'h30;
   localparam logic [7:0]  FSS_LEN_BUSY_INT  = 8'h60;
   localparam logic [7:0]  FSS_LEN_BUSY_A    = 8'hb8;
   localparam logic [7:0]  FSS_LEN_BUSY_B    = 8'hd8;

   // opcode fields
   localparam logic [3:0]  FSS_OP_LINE       = 4'hf;
   localparam logic [2:0]  FSS_OP_TYPE       = 3'h4;
   localparam int          FSS_OP_LINE_HI    = 15;
   localparam int          FSS_OP_LINE_LO    = 12;
   localparam int          FSS_OP_ID_HI      = 11;
   localparam int          FSS_OP_ID_LO      = 9;
   localparam int          FSS_OP_TYPE_HI    = 8;
   localparam int          FSS_OP_TYPE_LO    = 6;
   localparam int          FSS_OP_MODE_HI    = 5;
   localparam int          FSS_OP_MODE_LO    = 3;
   localparam int          FSS_OP_REG_HI     = 2;
   localparam int          FSS_OP_REG_LO     = 0;

   // effective-address modes
   localparam logic [2:0]  FSS_EA_IND        = 3'h2;
   localparam logic [2:0]  FSS_EA_PREDEC     = 3'h4;
   localparam logic [2:0]  FSS_EA_DISP       = 3'h5;
   localparam logic [2:0]  FSS_EA_INDEX      = 3'h6;
   localparam logic [2:0]  FSS_EA_EXT        = 3'h7;
   localparam logic [2:0]  FSS_EA_ABS_W      = 3'h0;
   localparam logic [2:0]  FSS_EA_ABS_L      = 3'h1;

   localparam logic [2:0]  FSS_COP_ID_RST    = 3'h1;

   typedef enum logic [0:0] {
      FSS_ST_READY  = 1'b0,
      FSS_ST_SAVING = 1'b1
   } fss_state_e;
endpackage : fss_pkg

// ==== fss_host_model.sv ====
// Purpose: host core model for the fp state-save handshake
// Assumes: one save at a time, begun by a pulse on start
// Notes:   frame store waits while hold is high
`timescale 1ns/1ps
module fss_host_model (
   input  wire logic        sys_clk,
   input  wire logic        start,
   input  wire logic        hold,
   input  wire logic        save_valid_r,
   input  wire logic [15:0] save_word_r,
   output logic             save_rd,
   output logic             frame_stored,
   output logic             done,
   output logic [15:0]      word_seen,
   output logic [3:0]       retries
);
   initial begin
      save_rd = 1'b0;
      frame_stored = 1'b0;
      done = 1'b0;
      word_seen = 16'h0000;
      retries = 4'h0;
      forever begin
         @(posedge sys_clk);
         // supervisor-only host; frame goes out before register moves
         if (start) begin
            done = 1'b0;
            retries = 4'h0;
            word_seen = 16'h0118;
            while (word_seen == 16'h0118) begin
               @(negedge sys_clk);
               save_rd = 1'b1;
               @(negedge sys_clk);
               save_rd = 1'b0;
               word_seen = save_valid_r ? save_word_r : 16'hffff;
               if (word_seen == 16'h0118) begin
                  retries = retries + 4'h1;
                  // gap stands for interrupt service
                  repeat (3) @(negedge sys_clk);
               end
            end
            if (word_seen !== 16'h0218) begin
               while (hold) @(negedge sys_clk);
               frame_stored = 1'b1;
               @(negedge sys_clk);
               frame_stored = 1'b0;
            end
            done = 1'b1;
         end
      end
   end
endmodule : fss_host_model

// ==== fss_state_save_tb.sv ====
// Purpose: self-checking bench for the fp state-save handshake
// Assumes: integrated variant, host model makes the save reads, tb_rd adds the save-in-save and frozen reads
// Notes:   inputs change on the falling edge
`timescale 1ns/1ps
module fss_state_save_tb
   import fss_pkg::*;
();
   localparam logic [2:0] MD [11] = '{3'h2, 3'h4, 3'h5, 3'h6, 3'h7, 3'h7,
                                     3'h0, 3'h1, 3'h3, 3'h7, 3'h7};
   localparam logic [2:0] RG [11] = '{3'h0, 3'h3, 3'h1, 3'h2, 3'h0, 3'h1,
                                     3'h0, 3'h0, 3'h0, 3'h2, 3'h4};
   logic        sys_clk, srst, clk_en, instr_valid, start, hold, tb_rd;
   logic        op_running, op_can_finish, fp_activity, restore_null;
   logic        exc_early, exc_late, exc_unsupp, exc_other, unimpl_instr;
   logic        host_rd, frame_stored, done, save_instr_r, ea_reject_r;
   logic        save_valid_r, model_is_reset_r, saving_r, op_hold;
   logic [2:0]  cop_id;
   logic [15:0] instr_word, save_word_r, word_seen;
   logic [7:0]  frame_len_r;
   logic [3:0]  retries;
   int          failures, total_checks;
   ////////////////////////////////////////
   fss_state_save #(.VARIANT(FSS_VAR_INTEG)) u_fss_state_save (
      .sys_clk(sys_clk), .srst(srst), .clk_en(clk_en), .cop_id(cop_id),
      .instr_valid(instr_valid), .instr_word(instr_word),
      .save_rd(host_rd | tb_rd), .frame_stored(frame_stored),
      .op_running(op_running), .op_can_finish(op_can_finish),
      .fp_activity(fp_activity), .restore_null(restore_null),
      .unimpl_instr(unimpl_instr), .exc_early(exc_early),
      .exc_late(exc_late), .exc_unsupp(exc_unsupp), .exc_other(exc_other),
      .save_instr_r(save_instr_r), .ea_reject_r(ea_reject_r),
      .save_valid_r(save_valid_r), .save_word_r(save_word_r),
      .frame_len_r(frame_len_r), .model_is_reset_r(model_is_reset_r),
      .saving_r(saving_r));
   fss_host_model u_fss_host_model (
      .sys_clk(sys_clk), .start(start), .hold(hold),
      .save_valid_r(save_valid_r), .save_word_r(save_word_r),
      .save_rd(host_rd), .frame_stored(frame_stored), .done(done),
      .word_seen(word_seen), .retries(retries));
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : tick
   task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                        input string what);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: %s seen %h want %h", $time, what, seen, exp);
      end
   endtask : check
   task automatic end_of_test();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   task automatic wait_hi(ref logic sig);
      int n = 0;
      while (sig !== 1'b1 && n < 300) begin
         tick(1);
         n++;
      end
      if (sig !== 1'b1) begin
         failures++;
         $display("Error at %0t: wait ran out", $time);
         end_of_test();
      end
   endtask : wait_hi
   task automatic do_save(input logic [15:0] w, input logic [7:0] len);
      start = 1'b1;
      tick(1);
      start = 1'b0;
      wait_hi(done);
      check(word_seen, w, "format word");
      check({8'h00, frame_len_r}, {8'h00, len}, "length");
   endtask : do_save
   task automatic t_null();
      check({15'h0000, model_is_reset_r}, 16'h0001, "reset model");
      hold = 1'b1;
      start = 1'b1;
      tick(1);
      start = 1'b0;
      wait_hi(saving_r);
      check(save_word_r, FSS_FMT_NULL, "null word");
      check({8'h00, frame_len_r}, {8'h00, FSS_LEN_NULL}, "null len");
      tb_rd = 1'b1;
      tick(1);
      tb_rd = 1'b0;
      check(save_word_r, FSS_FMT_ILLEGAL, "save in save");
      check({15'h0000, save_valid_r}, 16'h0001, "answer valid");
      check({15'h0000, saving_r}, 16'h0001, "save kept");
      hold = 1'b0;
      wait_hi(done);
      tick(2);
      check({15'h0000, saving_r}, 16'h0000, "idle after");
      check(word_seen, FSS_FMT_NULL, "host word");
   endtask : t_null
   task automatic t_wait_idle();
      fp_activity = 1'b1;
      tick(1);
      fp_activity = 1'b0;
      check({15'h0000, model_is_reset_r}, 16'h0000, "touched");
      op_hold = 1'b1;
      op_can_finish = 1'b1;
      do_save({FSS_VERSION, FSS_FMT_IDLE_LO}, FSS_LEN_IDLE_INT);
      op_hold = 1'b0;
      check({15'h0000, retries != 4'h0}, 16'h0001, "not ready");
      restore_null = 1'b1;
      tick(1);
      restore_null = 1'b0;
      check({15'h0000, model_is_reset_r}, 16'h0001, "null restore");
      tick(1);
      do_save(FSS_FMT_NULL, FSS_LEN_NULL);
   endtask : t_wait_idle
   task automatic t_frames();
      logic [15:0] w;
      logic [7:0]  n;
      logic        busy;
      fp_activity = 1'b1;
      tick(1);
      fp_activity = 1'b0;
      for (int i = 1; i < 32; i++) begin
         {exc_early, exc_late, exc_unsupp, unimpl_instr, exc_other} = i[4:0];
         busy = exc_late | exc_unsupp | exc_other;
         w = {FSS_VERSION, busy ? FSS_FMT_BUSY_LO : FSS_FMT_UTYPE_LO};
         n = busy ? FSS_LEN_BUSY_INT : FSS_LEN_UTYPE;
         do_save(w, n);
      end
      {exc_early, exc_late, exc_unsupp, unimpl_instr, exc_other} = 5'h00;
   endtask : t_frames
   task automatic t_decode();
      instr_valid = 1'b1;
      for (int i = 0; i < 13; i++) begin
         instr_word = {FSS_OP_LINE, cop_id, FSS_OP_TYPE, MD[i%11], RG[i%11]};
         if (i == 11)
            instr_word[11:9] = ~cop_id;
         if (i == 12)
            instr_word[8:6] = 3'h5;
         tick(1);
         check({14'h0000, save_instr_r, ea_reject_r},
               {14'h0000, i < 6, i >= 6 && i < 11}, "decode");
      end
      instr_valid = 1'b0;
   endtask : t_decode
   // a read while frozen must neither answer nor start a save
   task automatic t_freeze();
      clk_en = 1'b0;
      tb_rd = 1'b1;
      tick(2);
      tb_rd = 1'b0;
      check({15'h0000, save_valid_r}, 16'h0000, "frozen read");
      check({15'h0000, saving_r}, 16'h0000, "frozen save");
      clk_en = 1'b1;
      tick(1);
   endtask : t_freeze
   initial begin
      {srst, clk_en, instr_valid, start, hold, tb_rd} = 6'h20;
      {op_hold, op_can_finish, fp_activity, restore_null} = 4'h0;
      {exc_early, exc_late, exc_unsupp, unimpl_instr, exc_other} = 5'h00;
      cop_id = FSS_COP_ID_RST;
      instr_word = 16'h0000;
      failures = 0;
      total_checks = 0;
      clk_en = 1'b1;
      tick(12);
      srst = 1'b0;
      t_null();
      t_wait_idle();
      t_frames();
      t_decode();
      t_freeze();
      end_of_test();
   end
   // sole driver of op_running: the op ends after two not-ready answers
   always @(negedge sys_clk)
      op_running <= op_hold && (retries < 4'h2);
endmodule : fss_state_save_tb
